// File: core/pmc_pkg.sv
package pmc_pkg;
    // command codes
    localparam logic [7:0] CMD_POWER_STATE = 8'h01;
    localparam logic [7:0] CMD_START_SRC = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] CMD_STORE_DEFAULT = 8'h11;
    localparam logic [7:0] CMD_RESTORE_DEFAULT = 8'h12;
    localparam logic [7:0] CMD_STORE_USER = 8'h15;
    localparam logic [7:0] CMD_RESTORE_USER = 8'h16;
    localparam logic [7:0] CMD_VFORMAT = 8'h20;
    localparam logic [7:0] CMD_VTARGET = 8'h21;
    localparam logic [7:0] CMD_VTRIM = 8'h22;
    localparam logic [7:0] CMD_VCAL = 8'h23;
    localparam logic [7:0] CMD_VCEIL = 8'h24;
    // field positions
    localparam int PSC_ONOFF_HI = 7;
    localparam int PSC_ONOFF_LO = 6;
    localparam int PSC_MARGIN_HI = 5;
    localparam int PSC_MARGIN_LO = 4;
    localparam int SSC_SRC_HI = 4;
    localparam int SSC_SRC_LO = 2;
    localparam int SSC_POL_BIT = 1;
    localparam int SSC_FAST_OFF_BIT = 0;
    // field codes
    localparam logic [1:0] ONOFF_IMMEDIATE = 2'h0;
    localparam logic [1:0] ONOFF_SOFT = 2'h1;
    localparam logic [1:0] ONOFF_ON = 2'h2;
    localparam logic [1:0] MARGIN_NOMINAL = 2'h0;
    localparam logic [1:0] MARGIN_LOW = 2'h1;
    localparam logic [1:0] MARGIN_HIGH = 2'h2;
    localparam logic [2:0] SRC_ALWAYS = 3'h0;
    localparam logic [2:0] SRC_PIN = 3'h5;
    localparam logic [2:0] SRC_CMD = 3'h6;
    localparam logic [2:0] SRC_BOTH = 3'h7;
    // reset values
    localparam logic [7:0] PSC_RESET = 8'h00;
    localparam logic [7:0] SSC_RESET = 8'h16;
    localparam logic [7:0] VFORMAT_VALUE = 8'h13;
    localparam logic [15:0] VTRIM_RESET = 16'h0000;
    localparam logic [15:0] VCAL_RESET = 16'h0000;
    localparam logic [1:0] SECURITY_RESTORED = 2'h1;
    localparam logic [15:0] V_LIMIT_4V = 16'h8000;
    // timing
    localparam int CLK_HZ = 20000000;
    localparam int STORE_BUSY_MS = 20;
    localparam int STORE_BUSY_CYCLES = (CLK_HZ / 1000) * STORE_BUSY_MS;
    localparam int RESTORE_CYCLES = 2;
    localparam int NUM_SETTINGS = 7;
endpackage

// File: core/pmc_core.sv
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - on/off bits 7:6: 00 immediate off, 01 soft off, 10 on
// - when on, bits 5:4 pick nominal, low or high margin if margin pin open
// - any other power-state byte pattern flags a command error
// - start source bits 4:2: always, pin only, command only, both
// - bit 1 sets enable pin polarity, 1 means active high
// - bit 0: pin turn-off immediate if 1, ramped if 0
// - start source config resets to 16h
// - clear faults clears every fault bit and releases alert output
// - a fault still present sets its bit again at once
// - clear faults never restarts a shut-down output
// - store default saves settings; host waits 20 ms afterwards
// - restore default copies default store into operating settings
// - power-up loads default store, user store overrides
// - any restore completion sets security level to 1
// - store user saves all settings; bus unresponsive 20 ms meanwhile
// - restore user copies user store; done at power-up and on demand
// - voltage format register is read-only 13h
// - target voltage rejects values above ceiling or 110% of strap
// - trim is signed, resets to 0000h
// - calibration offset adds signed offset, resets to 0000h
// - ceiling caps output, range up to 4 V, resets to 1.10 times strap
// - unsigned voltage words scale by 2^-13
// - signed voltage words scale by 2^-13
module pmc_core
#(
    parameter int STORE_BUSY = pmc_pkg::STORE_BUSY_CYCLES
)
(
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire logic CMD_VALID_I,
    input wire logic [7:0] CMD_CODE_I,
    input wire logic CMD_WRITE_I,
    input wire logic [15:0] CMD_DATA_I,
    input wire logic [15:0] STRAP_VOUT_I,
    input wire logic [15:0] MARGIN_HIGH_I,
    input wire logic [15:0] MARGIN_LOW_I,
    input wire logic ENABLE_PIN_I,
    input wire logic MARGIN_SELECT_PIN_OPEN_I,
    input wire logic [7:0] FAULT_COND_I,
    input wire logic USER_STORE_VALID_I,
    output logic CMD_ACK_O,
    output logic CMD_ERROR_O,
    output logic BUSY_O,
    output logic [15:0] READ_DATA_O,
    output logic OUTPUT_ON_O,
    output logic FAST_OFF_O,
    output logic [15:0] VOUT_TARGET_O,
    output logic [7:0] FAULT_BITS_O,
    output logic BUS_ALERT_OUTPUT_N_O,
    output logic [1:0] SECURITY_LEVEL_O
);
    import pmc_pkg::*;

    typedef enum logic [3:0]
    {
        ST_POWERUP = 4'b0001,
        ST_IDLE = 4'b0010,
        ST_BUSY = 4'b0100,
        ST_RESTORE = 4'b1000
    } pmc_state_type;

    typedef struct packed
    {
        pmc_state_type st;
        logic [24:0] cnt;
        logic init;
        logic sel_user;
        logic [7:0] psc;
        logic [7:0] ssc;
        logic [15:0] vtarget;
        logic [15:0] vtrim;
        logic [15:0] vcal;
        logic [15:0] vceil;
        logic [15:0] strap;
        logic [7:0] dflt_psc;
        logic [7:0] dflt_ssc;
        logic [15:0] dflt_vt;
        logic [15:0] dflt_tr;
        logic [15:0] dflt_ca;
        logic [15:0] dflt_ce;
        logic [7:0] usr_psc;
        logic [7:0] usr_ssc;
        logic [15:0] usr_vt;
        logic [15:0] usr_tr;
        logic [15:0] usr_ca;
        logic [15:0] usr_ce;
        logic en_s1;
        logic en_s2;
        logic mg_s1;
        logic mg_s2;
        logic [7:0] fc_s1;
        logic [7:0] fc_s2;
        logic ack;
        logic err;
        logic [15:0] rdata;
        logic on;
        logic fast_off;
        logic [15:0] vout;
        logic [7:0] faults;
        logic alert_n;
        logic [1:0] sec;
        logic busy;
    } pmc_regs_type;

    pmc_regs_type r_q;
    pmc_regs_type r_d;

    // 110% of a value, unsigned, saturating
    function automatic logic [15:0] pct110(input logic [15:0] v);
        logic [19:0] p;
        p = ({4'h0, v} * 20'hB) / 20'hA;
        pct110 = (p[19:16] != 4'h0) ? 16'hFFFF : p[15:0];
    endfunction

    // legal power-state patterns
    function automatic logic psc_legal(input logic [7:0] b);
        psc_legal = (b[3:0] == 4'h0) &&
            ((b[7:6] == ONOFF_ON && b[5:4] != 2'h3) || (b[7:6] != ONOFF_ON && b[7:6] != 2'h3 && b[5:4] == 2'h0));
    endfunction

    logic [1:0] onoff;
    logic [1:0] margin;
    logic [2:0] src;
    logic pin_active;
    logic cmd_on;
    logic want_on;
    logic [15:0] base;
    logic [17:0] sum;
    logic [15:0] lim;

    always_comb
    begin
        r_d = r_q;
        r_d.ack = 1'b0;
        r_d.err = 1'b0;
        r_d.en_s1 = ENABLE_PIN_I;
        r_d.en_s2 = r_q.en_s1;
        r_d.mg_s1 = MARGIN_SELECT_PIN_OPEN_I;
        r_d.mg_s2 = r_q.mg_s1;
        r_d.fc_s1 = FAULT_COND_I;
        r_d.fc_s2 = r_q.fc_s1;
        // sticky faults: set wins over clear
        r_d.faults = r_q.faults | r_q.fc_s2;
        onoff = r_q.psc[PSC_ONOFF_HI:PSC_ONOFF_LO];
        margin = r_q.psc[PSC_MARGIN_HI:PSC_MARGIN_LO];
        src = r_q.ssc[SSC_SRC_HI:SSC_SRC_LO];
        pin_active = r_q.en_s2 == r_q.ssc[SSC_POL_BIT];
        cmd_on = onoff == ONOFF_ON;
        case (src)
            SRC_ALWAYS: want_on = 1'b1;
            SRC_PIN: want_on = pin_active;
            SRC_CMD: want_on = cmd_on;
            SRC_BOTH: want_on = pin_active && cmd_on;
            default: want_on = 1'b0;
        endcase
        r_d.on = want_on && !r_q.init;
        // command off is immediate only for 00; pin off follows config
        if (r_q.on && !want_on)
        begin
            if (src != SRC_ALWAYS && src != SRC_PIN && !cmd_on)
                r_d.fast_off = onoff == ONOFF_IMMEDIATE;
            else
                r_d.fast_off = r_q.ssc[SSC_FAST_OFF_BIT];
        end
        // margin only from the command while pin is open
        base = r_q.vtarget;
        if (cmd_on && r_q.mg_s2)
        begin
            if (margin == MARGIN_LOW)
                base = MARGIN_LOW_I;
            else if (margin == MARGIN_HIGH)
                base = MARGIN_HIGH_I;
        end
        // voltages are 2^-13 scaled mantissas; trim and offset signed
        sum = {2'b00, base} + {{2{r_q.vtrim[15]}}, r_q.vtrim} + {{2{r_q.vcal[15]}}, r_q.vcal};
        lim = r_q.vceil;
        if (sum[17])
            r_d.vout = 16'h0000;
        else if (sum[16] || sum[15:0] > lim)
            r_d.vout = lim;
        else
            r_d.vout = sum[15:0];

        case (r_q.st)
            ST_POWERUP:
            begin
                r_d.strap = STRAP_VOUT_I;
                r_d.vtarget = STRAP_VOUT_I;
                r_d.vceil = pct110(STRAP_VOUT_I);
                r_d.dflt_psc = PSC_RESET;
                r_d.dflt_ssc = SSC_RESET;
                r_d.dflt_vt = STRAP_VOUT_I;
                r_d.dflt_tr = VTRIM_RESET;
                r_d.dflt_ca = VCAL_RESET;
                r_d.dflt_ce = pct110(STRAP_VOUT_I);
                r_d.sel_user = USER_STORE_VALID_I;
                r_d.cnt = 25'h0;
                r_d.st = ST_RESTORE;
            end
            ST_RESTORE:
            begin
                // default first, user overrides when present
                r_d.psc = r_q.dflt_psc;
                r_d.ssc = r_q.dflt_ssc;
                r_d.vtarget = r_q.dflt_vt;
                r_d.vtrim = r_q.dflt_tr;
                r_d.vcal = r_q.dflt_ca;
                r_d.vceil = r_q.dflt_ce;
                if (r_q.sel_user)
                begin
                    r_d.psc = r_q.usr_psc;
                    r_d.ssc = r_q.usr_ssc;
                    r_d.vtarget = r_q.usr_vt;
                    r_d.vtrim = r_q.usr_tr;
                    r_d.vcal = r_q.usr_ca;
                    r_d.vceil = r_q.usr_ce;
                end
                r_d.sec = SECURITY_RESTORED;
                r_d.init = 1'b0;
                r_d.ack = !r_q.init;
                r_d.st = ST_IDLE;
            end
            ST_BUSY:
            begin
                // commands ignored while nonvolatile store runs
                if (r_q.cnt == 25'(STORE_BUSY - 1))
                begin
                    r_d.ack = 1'b1;
                    r_d.st = ST_IDLE;
                end
                r_d.cnt = r_q.cnt + 25'h1;
            end
            ST_IDLE:
            begin
                if (CMD_VALID_I)
                begin
                    r_d.ack = 1'b1;
                    case (CMD_CODE_I)
                        CMD_POWER_STATE:
                        begin
                            r_d.rdata = {8'h00, r_q.psc};
                            if (CMD_WRITE_I)
                            begin
                                r_d.psc = CMD_DATA_I[7:0];
                                r_d.err = !psc_legal(CMD_DATA_I[7:0]);
                            end
                        end
                        CMD_START_SRC:
                        begin
                            r_d.rdata = {8'h00, r_q.ssc};
                            if (CMD_WRITE_I)
                                r_d.ssc = CMD_DATA_I[7:0];
                        end
                        CMD_CLEAR_FAULTS:
                        begin
                            // present faults re-set; output state untouched
                            r_d.faults = r_q.fc_s2;
                            r_d.alert_n = 1'b1;
                        end
                        CMD_STORE_DEFAULT:
                        begin
                            r_d.dflt_psc = r_q.psc;
                            r_d.dflt_ssc = r_q.ssc;
                            r_d.dflt_vt = r_q.vtarget;
                            r_d.dflt_tr = r_q.vtrim;
                            r_d.dflt_ca = r_q.vcal;
                            r_d.dflt_ce = r_q.vceil;
                        end
                        CMD_RESTORE_DEFAULT:
                        begin
                            r_d.sel_user = 1'b0;
                            r_d.ack = 1'b0;
                            r_d.st = ST_RESTORE;
                        end
                        CMD_STORE_USER:
                        begin
                            r_d.usr_psc = r_q.psc;
                            r_d.usr_ssc = r_q.ssc;
                            r_d.usr_vt = r_q.vtarget;
                            r_d.usr_tr = r_q.vtrim;
                            r_d.usr_ca = r_q.vcal;
                            r_d.usr_ce = r_q.vceil;
                            r_d.ack = 1'b0;
                            r_d.cnt = 25'h0;
                            r_d.st = ST_BUSY;
                        end
                        CMD_RESTORE_USER:
                        begin
                            r_d.sel_user = 1'b1;
                            r_d.ack = 1'b0;
                            r_d.st = ST_RESTORE;
                        end
                        CMD_VFORMAT:
                        begin
                            r_d.rdata = {8'h00, VFORMAT_VALUE};
                            r_d.err = CMD_WRITE_I;
                        end
                        CMD_VTARGET:
                        begin
                            r_d.rdata = r_q.vtarget;
                            if (CMD_WRITE_I)
                            begin
                                if (CMD_DATA_I > r_q.vceil || CMD_DATA_I > pct110(r_q.strap))
                                    r_d.err = 1'b1;
                                else
                                    r_d.vtarget = CMD_DATA_I;
                            end
                        end
                        CMD_VTRIM:
                        begin
                            r_d.rdata = r_q.vtrim;
                            if (CMD_WRITE_I)
                                r_d.vtrim = CMD_DATA_I;
                        end
                        CMD_VCAL:
                        begin
                            r_d.rdata = r_q.vcal;
                            if (CMD_WRITE_I)
                                r_d.vcal = CMD_DATA_I;
                        end
                        CMD_VCEIL:
                        begin
                            r_d.rdata = r_q.vceil;
                            if (CMD_WRITE_I)
                            begin
                                if (CMD_DATA_I > V_LIMIT_4V)
                                    r_d.err = 1'b1;
                                else
                                    r_d.vceil = CMD_DATA_I;
                            end
                        end
                        default:
                        begin
                            r_d.rdata = 16'h0000;
                            r_d.err = 1'b1;
                        end
                    endcase
                end
            end
            default:
                r_d.st = ST_POWERUP;
        endcase
        if (r_d.faults != 8'h00 && r_q.faults == 8'h00 && r_q.fc_s2 != 8'h00)
            r_d.alert_n = 1'b0;
        r_d.busy = r_d.st != ST_IDLE;
    end

    always_ff @(posedge CLOCK_I)
    begin
        if (!RESET_N_I)
        begin
            r_q <= '0;
            r_q.st <= ST_POWERUP;
            r_q.init <= 1'b1;
            r_q.ssc <= SSC_RESET;
            r_q.psc <= PSC_RESET;
            r_q.vtrim <= VTRIM_RESET;
            r_q.vcal <= VCAL_RESET;
            r_q.alert_n <= 1'b1;
            r_q.busy <= 1'b1;
            // user store is nonvolatile, so reset leaves it alone
            r_q.usr_psc <= r_q.usr_psc;
            r_q.usr_ssc <= r_q.usr_ssc;
            r_q.usr_vt <= r_q.usr_vt;
            r_q.usr_tr <= r_q.usr_tr;
            r_q.usr_ca <= r_q.usr_ca;
            r_q.usr_ce <= r_q.usr_ce;
        end
        else
            r_q <= r_d;
    end

    assign CMD_ACK_O = r_q.ack;
    assign CMD_ERROR_O = r_q.err;
    assign BUSY_O = r_q.busy;
    assign READ_DATA_O = r_q.rdata;
    assign OUTPUT_ON_O = r_q.on;
    assign FAST_OFF_O = r_q.fast_off;
    assign VOUT_TARGET_O = r_q.vout;
    assign FAULT_BITS_O = r_q.faults;
    assign BUS_ALERT_OUTPUT_N_O = r_q.alert_n;
    assign SECURITY_LEVEL_O = r_q.sec;
endmodule
`default_nettype wire

// File: tb/pmc_core_checker.sv
`timescale 1ns/100ps
`default_nettype none
module pmc_core_checker
import pmc_pkg::*;
#(
    parameter int STORE_BUSY = 10
)
(
    input wire logic CLOCK_I,
    input wire logic RESET_N_I,
    input wire logic CMD_VALID_I,
    input wire logic [7:0] CMD_CODE_I,
    input wire logic CMD_WRITE_I,
    input wire logic [15:0] CMD_DATA_I,
    input wire logic [15:0] STRAP_VOUT_I,
    input wire logic [7:0] FAULT_COND_I,
    input wire logic CMD_ACK_O,
    input wire logic CMD_ERROR_O,
    input wire logic BUSY_O,
    input wire logic [15:0] READ_DATA_O,
    input wire logic [7:0] FAULT_BITS_O,
    input wire logic BUS_ALERT_OUTPUT_N_O,
    input wire logic [1:0] SECURITY_LEVEL_O
);
    // ack window follows the eight quiet cycles, one cycle slack each side
    localparam int ACK_LO = STORE_BUSY - 8;
    localparam int ACK_HI = STORE_BUSY - 6;
    logic tk;
    logic wt;
    logic [31:0] lim;
    assign tk = CMD_VALID_I && !BUSY_O;
    assign wt = tk && CMD_WRITE_I;
    // 110 percent of strap, truncated as the design does
    assign lim = ({16'h0000, STRAP_VOUT_I} * 32'h0000000B) / 32'h0000000A;
    default clocking cb @(posedge CLOCK_I);
    endclocking
    default disable iff (!RESET_N_I);
    sequence s_store_taken;
        tk && CMD_CODE_I == CMD_STORE_USER;
    endsequence
    sequence s_store_quiet;
        (BUSY_O && !CMD_ACK_O) [*8];
    endsequence
    a_store_goes_quiet: assert property (s_store_taken |=> s_store_quiet ##[ACK_LO:ACK_HI] CMD_ACK_O)
        else $error("store user busy window wrong");
    a_format_fixed: assert property (tk && !CMD_WRITE_I && CMD_CODE_I == CMD_VFORMAT |=>
        CMD_ACK_O && READ_DATA_O == {8'h00, VFORMAT_VALUE}) else $error("format read wrong");
    a_format_locked: assert property (wt && CMD_CODE_I == CMD_VFORMAT |=> CMD_ERROR_O)
        else $error("format write accepted");
    a_target_bounded: assert property (wt && CMD_CODE_I == CMD_VTARGET && {16'h0000, CMD_DATA_I} > lim
        |=> CMD_ERROR_O) else $error("target above strap limit accepted");
    a_ceiling_bounded: assert property (wt && CMD_CODE_I == CMD_VCEIL && CMD_DATA_I > V_LIMIT_4V
        |=> CMD_ERROR_O) else $error("ceiling above 4 V accepted");
    a_state_byte_checked: assert property (wt && CMD_CODE_I == CMD_POWER_STATE && CMD_DATA_I[3:0] != 4'h0
        |=> CMD_ACK_O && CMD_ERROR_O) else $error("bad power state byte not flagged");
    a_restore_level: assert property (tk && (CMD_CODE_I == CMD_RESTORE_USER ||
        CMD_CODE_I == CMD_RESTORE_DEFAULT) |-> ##[1:3] (CMD_ACK_O && SECURITY_LEVEL_O == SECURITY_RESTORED))
        else $error("restore did not set security level");
    a_clear_releases: assert property (tk && CMD_CODE_I == CMD_CLEAR_FAULTS && FAULT_COND_I == 8'h00 &&
        $past(FAULT_COND_I, 1) == 8'h00 && $past(FAULT_COND_I, 2) == 8'h00 |->
        ##[1:2] (FAULT_BITS_O == 8'h00 && BUS_ALERT_OUTPUT_N_O))
        else $error("clear faults left bits or alert");
endmodule
bind pmc_core pmc_core_checker #(.STORE_BUSY(STORE_BUSY)) u_checker (.CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I),
    .CMD_VALID_I(CMD_VALID_I), .CMD_CODE_I(CMD_CODE_I), .CMD_WRITE_I(CMD_WRITE_I), .CMD_DATA_I(CMD_DATA_I),
    .STRAP_VOUT_I(STRAP_VOUT_I), .FAULT_COND_I(FAULT_COND_I), .CMD_ACK_O(CMD_ACK_O), .CMD_ERROR_O(CMD_ERROR_O),
    .BUSY_O(BUSY_O), .READ_DATA_O(READ_DATA_O), .FAULT_BITS_O(FAULT_BITS_O),
    .BUS_ALERT_OUTPUT_N_O(BUS_ALERT_OUTPUT_N_O), .SECURITY_LEVEL_O(SECURITY_LEVEL_O));
`default_nettype wire

// File: tb/pmc_host.sv
`timescale 1ns/100ps
`default_nettype none
module pmc_host
#(
    parameter int SETTLE = 20
)
(
    input wire logic clk_i,
    input wire logic busy_i,
    input wire logic ack_i,
    input wire logic err_i,
    input wire logic [15:0] rd_i,
    output logic valid_o,
    output logic [7:0] code_o,
    output logic write_o,
    output logic [15:0] data_o
);
    import pmc_pkg::*;
    logic got_ok, got_err;
    logic [15:0] got_rd;
    initial
    begin
        valid_o = 1'b0;
        code_o = 8'hFF;
        write_o = 1'b0;
        data_o = 16'hFFFF;
    end
    task automatic issue(input logic [7:0] c, input logic w, input logic [15:0] d);
        int n;
        n = 0;
        while (busy_i !== 1'b0 && n < 40)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        @(posedge clk_i);
        valid_o <= 1'b1;
        code_o <= c;
        write_o <= w;
        data_o <= d;
        @(posedge clk_i);
        // released lines show the inverse so stale values cannot pass
        valid_o <= 1'b0;
        code_o <= ~c;
        write_o <= ~w;
        data_o <= ~d;
        #1;
        n = 0;
        while (ack_i !== 1'b1 && n < 40)
        begin
            @(posedge clk_i);
            #1;
            n++;
        end
        got_ok = (ack_i === 1'b1);
        got_err = err_i;
        got_rd = rd_i;
        // settle after a default store, scaled down from 20 ms
        if (c == CMD_STORE_DEFAULT)
            repeat (SETTLE) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// File: tb/pmc_core_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pmc_core_tb_top;
    import pmc_pkg::*;
    logic clk, rst_n, en, mgn_open, usv, valid, wr, ack, err, busy, on, fast, alert_n;
    logic [7:0] fault, code, fbits;
    logic [15:0] strap, mhi, mlo, wdata, rdata, vt, ceil_v, trim_v, cal_v, keep_v;
    logic [1:0] sec;
    logic [19:0] tbl [0:10];
    int errors, n_checks, seed;
    pmc_core #(.STORE_BUSY(10)) dut (.CLOCK_I(clk), .RESET_N_I(rst_n), .CMD_VALID_I(valid), .CMD_CODE_I(code),
        .CMD_WRITE_I(wr), .CMD_DATA_I(wdata), .STRAP_VOUT_I(strap), .MARGIN_HIGH_I(mhi), .MARGIN_LOW_I(mlo),
        .ENABLE_PIN_I(en), .MARGIN_SELECT_PIN_OPEN_I(mgn_open), .FAULT_COND_I(fault), .USER_STORE_VALID_I(usv),
        .CMD_ACK_O(ack), .CMD_ERROR_O(err), .BUSY_O(busy), .READ_DATA_O(rdata), .OUTPUT_ON_O(on),
        .FAST_OFF_O(fast), .VOUT_TARGET_O(vt), .FAULT_BITS_O(fbits), .BUS_ALERT_OUTPUT_N_O(alert_n),
        .SECURITY_LEVEL_O(sec));
    pmc_host #(.SETTLE(20)) host (.clk_i(clk), .busy_i(busy), .ack_i(ack), .err_i(err), .rd_i(rdata),
        .valid_o(valid), .code_o(code), .write_o(wr), .data_o(wdata));
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task close_out;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task cmd(input logic [7:0] c, input logic w, input logic [15:0] d, input logic e);
        host.issue(c, w, d);
        chk("ack", {15'h0000, host.got_ok}, 16'h0001);
        chk($sformatf("error %h", c), {15'h0000, host.got_err}, {15'h0000, e});
    endtask
    task rd(input logic [7:0] c, input logic [15:0] exp);
        cmd(c, 1'b0, 16'h0000, 1'b0);
        chk($sformatf("read %h", c), host.got_rd, exp);
    endtask
    // synchroniser latency plus margin
    task settle;
        repeat (6) @(posedge clk);
        #1;
    endtask
    function automatic logic [15:0] eff(input logic [15:0] b, t, o, m);
        logic signed [17:0] s;
        s = $signed({2'b00, b}) + $signed({{2{t[15]}}, t}) + $signed({{2{o[15]}}, o});
        if (s > $signed({2'b00, m}))
            return m;
        return s[15:0];
    endfunction
    initial
    begin
        #200000;
        errors++;
        close_out;
    end
    initial
    begin
        seed = 32'haf9b;
        errors = 0;
        n_checks = 0;
        {rst_n, en, mgn_open, usv, fault} = 12'h000;
        strap = 16'h2000 + (16'($random(seed)) & 16'h0FFF);
        mhi = strap + (16'($random(seed)) & 16'h00FF);
        mlo = strap - (16'($random(seed)) & 16'h00FF);
        ceil_v = 16'(({16'h0000, strap} * 32'h0000000B) / 32'h0000000A);
        tbl = '{20'h1600C, 20'h17003, 20'h14004, 20'h1400A, 20'h1880C, 20'h1840A, 20'h1880C, 20'h1800B,
            20'h1C808, 20'h1C804, 20'h0000C};
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(CMD_START_SRC, {8'h00, SSC_RESET});
        rd(CMD_VTRIM, VTRIM_RESET);
        rd(CMD_VCAL, VCAL_RESET);
        rd(CMD_VTARGET, strap);
        rd(CMD_VCEIL, ceil_v);
        rd(CMD_POWER_STATE, {8'h00, PSC_RESET});
        chk("security", {14'h0000, sec}, {14'h0000, SECURITY_RESTORED});
        $display("test power_up done");
        cmd(CMD_VFORMAT, 1'b1, 16'h00AA, 1'b1);
        rd(CMD_VFORMAT, {8'h00, VFORMAT_VALUE});
        cmd(CMD_VTARGET, 1'b1, ceil_v + 16'h0001, 1'b1);
        cmd(CMD_VCEIL, 1'b1, V_LIMIT_4V + 16'h0001, 1'b1);
        cmd(CMD_VCEIL, 1'b1, V_LIMIT_4V, 1'b0);
        ceil_v = ceil_v - 16'h0100;
        cmd(CMD_VCEIL, 1'b1, ceil_v, 1'b0);
        cmd(CMD_VTARGET, 1'b1, ceil_v + 16'h0001, 1'b1);
        rd(CMD_VTARGET, strap);
        cmd(CMD_POWER_STATE, 1'b1, 16'h0083, 1'b1);
        cmd(CMD_POWER_STATE, 1'b1, 16'h00C0, 1'b1);
        cmd(CMD_POWER_STATE, 1'b1, 16'h00B0, 1'b1);
        $display("test limits done");
        for (int i = 0; i < 4; i++)
        begin
            trim_v = 16'($random(seed));
            trim_v = {{6{trim_v[15]}}, trim_v[9:0]};
            cal_v = 16'($random(seed));
            cal_v = {{8{cal_v[7]}}, cal_v[7:0]};
            cmd(CMD_VTRIM, 1'b1, trim_v, 1'b0);
            cmd(CMD_VCAL, 1'b1, cal_v, 1'b0);
            rd(CMD_VTRIM, trim_v);
            rd(CMD_VCAL, cal_v);
        end
        for (int i = 0; i < 11; i++)
        begin
            cmd(CMD_START_SRC, 1'b1, {8'h00, tbl[i][19:12]}, 1'b0);
            @(posedge clk);
            en <= tbl[i][3];
            cmd(CMD_POWER_STATE, 1'b1, {8'h00, tbl[i][11:4]}, 1'b0);
            settle();
            chk("on", {15'h0000, on}, {15'h0000, tbl[i][2]});
            if (tbl[i][1])
                chk("fast_off", {15'h0000, fast}, {15'h0000, tbl[i][0]});
        end
        chk("target", vt, eff(strap, trim_v, cal_v, ceil_v));
        cmd(CMD_VTRIM, 1'b1, 16'h1000, 1'b0);
        settle();
        chk("target", vt, eff(strap, 16'h1000, cal_v, ceil_v));
        cmd(CMD_VTRIM, 1'b1, 16'h0000, 1'b0);
        cmd(CMD_START_SRC, 1'b1, 16'h0018, 1'b0);
        cmd(CMD_POWER_STATE, 1'b1, 16'h00A0, 1'b0);
        @(posedge clk);
        mgn_open <= 1'b1;
        settle();
        chk("margin", vt, eff(mhi, 16'h0000, cal_v, ceil_v));
        cmd(CMD_POWER_STATE, 1'b1, 16'h0090, 1'b0);
        settle();
        chk("margin", vt, eff(mlo, 16'h0000, cal_v, ceil_v));
        @(posedge clk);
        mgn_open <= 1'b0;
        settle();
        chk("margin", vt, eff(strap, 16'h0000, cal_v, ceil_v));
        $display("test power_control done");
        cmd(CMD_POWER_STATE, 1'b1, 16'h0000, 1'b0);
        @(posedge clk);
        fault <= 8'h05;
        settle();
        chk("faults", {8'h00, fbits}, 16'h0005);
        chk("alert", {15'h0000, alert_n}, 16'h0000);
        @(posedge clk);
        fault <= 8'h01;
        settle();
        cmd(CMD_CLEAR_FAULTS, 1'b1, 16'h0000, 1'b0);
        settle();
        chk("faults", {8'h00, fbits}, 16'h0001);
        chk("on", {15'h0000, on}, 16'h0000);
        @(posedge clk);
        fault <= 8'h00;
        settle();
        cmd(CMD_CLEAR_FAULTS, 1'b1, 16'h0000, 1'b0);
        settle();
        chk("faults", {8'h00, fbits}, 16'h0000);
        chk("alert", {15'h0000, alert_n}, 16'h0001);
        $display("test faults done");
        keep_v = 16'($random(seed));
        cmd(CMD_VTRIM, 1'b1, keep_v, 1'b0);
        cmd(CMD_STORE_USER, 1'b1, 16'h0000, 1'b0);
        cmd(CMD_VTRIM, 1'b1, ~keep_v, 1'b0);
        cmd(CMD_RESTORE_USER, 1'b1, 16'h0000, 1'b0);
        rd(CMD_VTRIM, keep_v);
        cmd(CMD_VTRIM, 1'b1, trim_v, 1'b0);
        cmd(CMD_STORE_DEFAULT, 1'b1, 16'h0000, 1'b0);
        cmd(CMD_VTRIM, 1'b1, ~trim_v, 1'b0);
        // output is off here, so the default restore is safe to send
        cmd(CMD_RESTORE_DEFAULT, 1'b1, 16'h0000, 1'b0);
        rd(CMD_VTRIM, trim_v);
        chk("security", {14'h0000, sec}, {14'h0000, SECURITY_RESTORED});
        @(posedge clk);
        rst_n <= 1'b0;
        usv <= 1'b1;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        rd(CMD_VTRIM, keep_v);
        $display("test stores done");
        close_out;
    end
endmodule
`default_nettype wire
